// ---- design/mepc_pkg.sv ----
// shared constants, register map and types of the motion event and power control block
package mepc_pkg;

    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int FF_MS_PER_COUNT = 5;
    localparam int INACT_MS_PER_COUNT = 1000;
    localparam int THR_SHIFT = 4;

    localparam int ADDR_W = 8;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_ACT_THR = 8'h24;
    localparam logic [7:0] IDX_INACT_THR = 8'h25;
    localparam logic [7:0] IDX_INACT_TIME = 8'h26;
    localparam logic [7:0] IDX_MOTION_AXIS = 8'h27;
    localparam logic [7:0] IDX_FF_THR = 8'h28;
    localparam logic [7:0] IDX_FF_TIME = 8'h29;
    localparam logic [7:0] IDX_TAP_AXIS = 8'h2A;
    localparam logic [7:0] IDX_EVENT_SRC = 8'h2B;
    localparam logic [7:0] IDX_RATE_POWER = 8'h2C;
    localparam logic [7:0] IDX_POWER_CONTROL = 8'h2D;

    localparam logic [7:0] RATE_POWER_RESET = 8'h0A;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam logic [7:0] TAP_AXIS_MASK = 8'h1F;
    localparam logic [7:0] RATE_POWER_MASK = 8'h1F;
    localparam logic [7:0] POWER_CONTROL_MASK = 8'h3F;

    localparam int ACT_AC_BIT = 7;
    localparam int ACT_EN_LSB = 4;
    localparam int INACT_AC_BIT = 3;
    localparam int INACT_EN_LSB = 0;
    localparam int TAP_IMPROVED_BIT = 4;
    localparam int TAP_SUPPRESS_BIT = 3;
    localparam int TAP_EN_LSB = 0;
    localparam int LOW_POWER_BIT = 4;
    localparam int RATE_LSB = 0;
    localparam int LINK_BIT = 5;
    localparam int AUTO_SLEEP_BIT = 4;
    localparam int MEASURE_BIT = 3;
    localparam int SLEEP_BIT = 2;
    localparam int DOZE_LSB = 0;

    localparam logic [9:0] DOZE_MS_00 = 10'h07D;
    localparam logic [9:0] DOZE_MS_01 = 10'h0FA;
    localparam logic [9:0] DOZE_MS_10 = 10'h1F4;
    localparam logic [9:0] DOZE_MS_11 = 10'h3E8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } mepc_axes_t;

    typedef enum logic [0:0] {
        MEPC_WAIT_INACT = 1'b0,
        MEPC_WAIT_ACT = 1'b1
    } mepc_link_t;

endpackage

// ---- design/mepc_tick_divider.sv ----
// millisecond time base derived from the system clock
`timescale 1ns/1ps
module mepc_tick_divider #(
    parameter int CYCLES = 125000
) (
    input wire logic ref_clk,
    input wire logic reset,
    output logic tickOut
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            tickOut <= 1'b0;
        end else begin
            tickOut <= (count_q == LAST);
            if (count_q == LAST) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + CW'(1);
            end
        end
    end
endmodule

// ---- design/mepc_top.sv ----
// motion event detection, tap configuration and power state with an AXI4-Lite register slave
// Contract
// - coupling bit: 0 dc direct, 1 ac
// - ac activity: reference at start, difference over threshold
// - ac inactivity: reference refreshed on exceed, timed
// - axis enables; none enabled disables function
// - free-fall: sum of squares versus threshold
// - free-fall event after below for time
// - improved tap uses output data samples
// - suppress rejects double tap on inter-tap exceed
// - tap axis enables gate tap axes
// - source bits overwritten by each new event
// - disabled axis source cleared at next event
// - asleep status bit reflects sleep mode
// - low-power bit selects reduced-power operation
// - rate field resets to 0x0A
// - link bit chains inactivity then activity
// - auto-sleep on inactivity when linked
// - measure bit; standby after reset
// - sleep: no ready, no fifo, doze rate
// - doze code sets sleep sampling period
// - activity threshold eight-bit, scaled compare
// - inactivity time in seconds, zero immediate
`timescale 1ns/1ps
module mepc_top
    import mepc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sampleValid,
    input wire mepc_axes_t sampleIn,
    input wire logic singleTapCandidate,
    input wire logic doubleTapCandidate,
    input wire logic [2:0] tapAxisHits,
    input wire logic tapAboveThreshold,
    output logic activityEvent,
    output logic inactivityEvent,
    output logic freefallEvent,
    output logic singleTapEvent,
    output logic doubleTapEvent,
    output logic [2:0] tapAxisEnable,
    output logic improvedTapMode,
    output logic lowPowerMode,
    output logic [3:0] outputRate,
    output logic measureMode,
    output logic asleepState,
    output logic sampleReadyAllowed,
    output logic fifoWriteAllowed
);
    function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        regHit = (a == ADDR_W'({idx[5:0], 2'b00}));
    endfunction

    function automatic logic [16:0] absMag(input logic signed [16:0] v);
        absMag = v[16] ? 17'(-v) : 17'(v);
    endfunction

    function automatic logic [16:0] scaledThr(input logic [7:0] t);
        scaledThr = {5'h00, t, 4'h0};
    endfunction

    function automatic logic [9:0] dozePeriod(input logic [1:0] code);
        case (code)
            2'h0: dozePeriod = DOZE_MS_00;
            2'h1: dozePeriod = DOZE_MS_01;
            2'h2: dozePeriod = DOZE_MS_10;
            default: dozePeriod = DOZE_MS_11;
        endcase
    endfunction

    logic [7:0] actThr_q, inactThr_q, inactTime_q, motionAxis_q;
    logic [7:0] ffThr_q, ffTime_q, tapAxis_q, ratePower_q, powerCtl_q;
    logic [2:0] actSrc_q, tapSrc_q;

    logic awHeld_q, wHeld_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic awTake, wTake, doWrite;
    logic awHeld_d, wHeld_d, bValid_d;
    logic [ADDR_W-1:0] wrAddr;
    logic [7:0] wrByte;
    logic wrLane, wrMapped;

    always_comb begin
        awTake = s_axi_awvalid & s_axi_awready;
        wTake = s_axi_wvalid & s_axi_wready;
        awHeld_d = awHeld_q | awTake;
        wHeld_d = wHeld_q | wTake;
        doWrite = awHeld_d & wHeld_d;
        bValid_d = (s_axi_bvalid & ~s_axi_bready) | doWrite;
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
        end
        wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
        wrByte = wHeld_q ? wData_q[7:0] : s_axi_wdata[7:0];
        wrLane = wHeld_q ? wStrb_q[0] : s_axi_wstrb[0];
        wrMapped = 1'b0;
        for (int r = 0; r < 10; r++) begin
            if (regHit(wrAddr, IDX_ACT_THR + 8'(r))) begin
                wrMapped = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            if (awTake) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            s_axi_awready <= ~awHeld_d & ~bValid_d;
            s_axi_wready <= ~wHeld_d & ~bValid_d;
            s_axi_bvalid <= bValid_d;
            if (doWrite) begin
                s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // status register is not writable; fixed-zero bits masked on write
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            actThr_q <= ZERO_RESET;
            inactThr_q <= ZERO_RESET;
            inactTime_q <= ZERO_RESET;
            motionAxis_q <= ZERO_RESET;
            ffThr_q <= ZERO_RESET;
            ffTime_q <= ZERO_RESET;
            tapAxis_q <= ZERO_RESET;
            ratePower_q <= RATE_POWER_RESET;
            powerCtl_q <= ZERO_RESET;
        end else if (doWrite && wrLane) begin
            if (regHit(wrAddr, IDX_ACT_THR)) actThr_q <= wrByte;
            if (regHit(wrAddr, IDX_INACT_THR)) inactThr_q <= wrByte;
            if (regHit(wrAddr, IDX_INACT_TIME)) inactTime_q <= wrByte;
            if (regHit(wrAddr, IDX_MOTION_AXIS)) motionAxis_q <= wrByte;
            if (regHit(wrAddr, IDX_FF_THR)) ffThr_q <= wrByte;
            if (regHit(wrAddr, IDX_FF_TIME)) ffTime_q <= wrByte;
            if (regHit(wrAddr, IDX_TAP_AXIS)) tapAxis_q <= wrByte & TAP_AXIS_MASK;
            if (regHit(wrAddr, IDX_RATE_POWER)) ratePower_q <= wrByte & RATE_POWER_MASK;
            if (regHit(wrAddr, IDX_POWER_CONTROL)) powerCtl_q <= wrByte & POWER_CONTROL_MASK;
        end
    end

    logic arTake, rValid_d;
    logic [7:0] rdByte;
    logic rdMapped;

    always_comb begin
        arTake = s_axi_arvalid & s_axi_arready;
        rValid_d = (s_axi_rvalid & ~s_axi_rready) | arTake;
        rdMapped = 1'b1;
        rdByte = 8'h00;
        if (regHit(s_axi_araddr, IDX_ACT_THR)) rdByte = actThr_q;
        else if (regHit(s_axi_araddr, IDX_INACT_THR)) rdByte = inactThr_q;
        else if (regHit(s_axi_araddr, IDX_INACT_TIME)) rdByte = inactTime_q;
        else if (regHit(s_axi_araddr, IDX_MOTION_AXIS)) rdByte = motionAxis_q;
        else if (regHit(s_axi_araddr, IDX_FF_THR)) rdByte = ffThr_q;
        else if (regHit(s_axi_araddr, IDX_FF_TIME)) rdByte = ffTime_q;
        else if (regHit(s_axi_araddr, IDX_TAP_AXIS)) rdByte = tapAxis_q;
        else if (regHit(s_axi_araddr, IDX_EVENT_SRC)) begin
            rdByte = {1'b0, actSrc_q, asleepState, tapSrc_q};
        end else if (regHit(s_axi_araddr, IDX_RATE_POWER)) rdByte = ratePower_q;
        else if (regHit(s_axi_araddr, IDX_POWER_CONTROL)) rdByte = powerCtl_q;
        else rdMapped = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~rValid_d;
            s_axi_rvalid <= rValid_d;
            if (arTake) begin
                s_axi_rdata <= {24'h000000, rdByte};
                s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    logic actAc, inactAc, linkOn, autoSleepOn, measureOn, sleepOn;
    logic [2:0] actEn, inactEn, tapEn;
    logic linkBoth, asleepNow, actArmed, inactArmed, msTick;
    mepc_link_t linkState_q;
    logic autoAsleep_q;

    assign actAc = motionAxis_q[ACT_AC_BIT];
    assign inactAc = motionAxis_q[INACT_AC_BIT];
    assign actEn = motionAxis_q[ACT_EN_LSB +: 3];
    assign inactEn = motionAxis_q[INACT_EN_LSB +: 3];
    assign tapEn = tapAxis_q[TAP_EN_LSB +: 3];
    assign linkOn = powerCtl_q[LINK_BIT];
    assign autoSleepOn = powerCtl_q[AUTO_SLEEP_BIT];
    assign measureOn = powerCtl_q[MEASURE_BIT];
    assign sleepOn = powerCtl_q[SLEEP_BIT];
    assign linkBoth = linkOn & (|actEn) & (|inactEn);
    assign asleepNow = sleepOn | autoAsleep_q;
    // no enabled axis switches the function off altogether
    assign actArmed = measureOn & (|actEn)
        & (~linkBoth | linkState_q == MEPC_WAIT_ACT);
    assign inactArmed = measureOn & (|inactEn) & ~asleepNow
        & (~linkBoth | linkState_q == MEPC_WAIT_INACT);

    mepc_tick_divider #(.CYCLES(TICK_CYCLES_P)) tickGen (
        .ref_clk(ref_clk),
        .reset(reset),
        .tickOut(msTick)
    );

    // sleep samples only once per doze period
    logic [9:0] dozeMs_q;
    logic dozeSlot_q, sampleTake;
    assign sampleTake = sampleValid & measureOn & (~asleepNow | dozeSlot_q);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dozeMs_q <= '0;
            dozeSlot_q <= 1'b0;
        end else if (!asleepNow) begin
            dozeMs_q <= '0;
            dozeSlot_q <= 1'b0;
        end else begin
            if (msTick) begin
                if (dozeMs_q >= dozePeriod(powerCtl_q[DOZE_LSB +: 2]) - 10'h001) begin
                    dozeMs_q <= '0;
                end else begin
                    dozeMs_q <= dozeMs_q + 10'h001;
                end
            end
            // a pending slot is consumed by the sample, a new one wins
            if (msTick && dozeMs_q >= dozePeriod(powerCtl_q[DOZE_LSB +: 2]) - 10'h001) begin
                dozeSlot_q <= 1'b1;
            end else if (sampleTake) begin
                dozeSlot_q <= 1'b0;
            end
        end
    end

    logic signed [15:0] axisVal [3];
    logic signed [15:0] actRef_q [3];
    logic signed [15:0] inactRef_q [3];
    logic [2:0] actHit, inactExceed;
    assign axisVal[2] = sampleIn.x;
    assign axisVal[1] = sampleIn.y;
    assign axisVal[0] = sampleIn.z;

    for (genvar i = 0; i < 3; i++) begin : gAxis
        logic signed [16:0] actDiff, inactDiff;
        assign actDiff = actAc ? 17'(axisVal[i]) - 17'(actRef_q[i]) : 17'(axisVal[i]);
        assign inactDiff = inactAc ? 17'(axisVal[i]) - 17'(inactRef_q[i]) : 17'(axisVal[i]);
        assign actHit[i] = actEn[i] & (absMag(actDiff) > scaledThr(actThr_q));
        assign inactExceed[i] = inactEn[i] & (absMag(inactDiff) >= scaledThr(inactThr_q));
    end

    logic actRefValid_q, inactRefValid_q, inactDone_q;
    logic [17:0] inactMs_q;
    logic actFire, inactFire;
    assign actFire = sampleTake & actArmed & (actRefValid_q | ~actAc) & (|actHit);
    // zero time fires on the first quiet sample
    assign inactFire = sampleTake & inactArmed & (inactRefValid_q | ~inactAc) & ~(|inactExceed)
        & ~inactDone_q
        & (inactMs_q >= 18'(inactTime_q) * 18'(INACT_MS_PER_COUNT));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            actRefValid_q <= 1'b0;
            for (int k = 0; k < 3; k++) actRef_q[k] <= '0;
        end else if (!actArmed) begin
            actRefValid_q <= 1'b0;
        end else if (sampleTake && !actRefValid_q) begin
            actRefValid_q <= 1'b1;
            for (int k = 0; k < 3; k++) actRef_q[k] <= axisVal[k];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            inactRefValid_q <= 1'b0;
            inactDone_q <= 1'b0;
            inactMs_q <= '0;
            for (int k = 0; k < 3; k++) inactRef_q[k] <= '0;
        end else if (!inactArmed) begin
            inactRefValid_q <= 1'b0;
            inactDone_q <= 1'b0;
            inactMs_q <= '0;
        end else begin
            if (sampleTake && (!inactRefValid_q || (|inactExceed))) begin
                inactRefValid_q <= 1'b1;
                inactDone_q <= 1'b0;
                inactMs_q <= '0;
                for (int k = 0; k < 3; k++) inactRef_q[k] <= axisVal[k];
            end else begin
                if (inactFire) inactDone_q <= 1'b1;
                if (msTick && inactMs_q != 18'h3FFFF) inactMs_q <= inactMs_q + 18'h00001;
            end
        end
    end

    logic [33:0] sumSq, thrSq;
    logic [11:0] ffMs_q;
    logic ffDone_q, ffBelow, ffArmed, ffFire;
    always_comb begin
        sumSq = 34'(sampleIn.x) * 34'(sampleIn.x) + 34'(sampleIn.y) * 34'(sampleIn.y)
            + 34'(sampleIn.z) * 34'(sampleIn.z);
        thrSq = 34'(scaledThr(ffThr_q)) * 34'(scaledThr(ffThr_q));
    end
    assign ffBelow = sumSq < thrSq;
    assign ffArmed = measureOn & ~asleepNow;
    assign ffFire = sampleTake & ffArmed & ffBelow & ~ffDone_q
        & (ffMs_q >= 12'(ffTime_q) * 12'(FF_MS_PER_COUNT));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ffMs_q <= '0;
            ffDone_q <= 1'b0;
        end else if (!ffArmed || (sampleTake && !ffBelow)) begin
            ffMs_q <= '0;
            ffDone_q <= 1'b0;
        end else begin
            if (ffFire) ffDone_q <= 1'b1;
            if (msTick && ffMs_q != 12'hFFF) ffMs_q <= ffMs_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            linkState_q <= MEPC_WAIT_INACT;
            autoAsleep_q <= 1'b0;
        end else begin
            if (!linkBoth) begin
                linkState_q <= MEPC_WAIT_INACT;
            end else if (inactFire) begin
                linkState_q <= MEPC_WAIT_ACT;
            end else if (actFire) begin
                linkState_q <= MEPC_WAIT_INACT;
            end
            if (!(linkOn && autoSleepOn) || !measureOn || actFire) begin
                autoAsleep_q <= 1'b0;
            end else if (inactFire) begin
                autoAsleep_q <= 1'b1;
            end
        end
    end

    logic tapGap_q, gapExceed_q, tapArmed, dblOk;
    assign tapArmed = measureOn & ~asleepNow & (|tapEn);
    assign dblOk = doubleTapCandidate & tapArmed
        & ~(tapAxis_q[TAP_SUPPRESS_BIT] & (gapExceed_q | tapAboveThreshold));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tapGap_q <= 1'b0;
            gapExceed_q <= 1'b0;
        end else if (singleTapCandidate) begin
            tapGap_q <= 1'b1;
            gapExceed_q <= 1'b0;
        end else if (doubleTapCandidate) begin
            tapGap_q <= 1'b0;
            gapExceed_q <= 1'b0;
        end else if (tapGap_q && tapAboveThreshold) begin
            gapExceed_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            actSrc_q <= 3'h0;
            tapSrc_q <= 3'h0;
        end else begin
            // masked overwrite drops a disabled axis only on the next event
            if (actFire) actSrc_q <= actHit & actEn;
            if ((singleTapCandidate && tapArmed) || dblOk) begin
                tapSrc_q <= tapAxisHits & tapEn;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            activityEvent <= 1'b0;
            inactivityEvent <= 1'b0;
            freefallEvent <= 1'b0;
            singleTapEvent <= 1'b0;
            doubleTapEvent <= 1'b0;
            tapAxisEnable <= 3'h0;
            improvedTapMode <= 1'b0;
            lowPowerMode <= 1'b0;
            outputRate <= RATE_POWER_RESET[3:0];
            measureMode <= 1'b0;
            asleepState <= 1'b0;
            sampleReadyAllowed <= 1'b0;
            fifoWriteAllowed <= 1'b0;
        end else begin
            activityEvent <= actFire;
            inactivityEvent <= inactFire;
            freefallEvent <= ffFire;
            singleTapEvent <= singleTapCandidate & tapArmed;
            doubleTapEvent <= dblOk;
            tapAxisEnable <= tapEn;
            improvedTapMode <= tapAxis_q[TAP_IMPROVED_BIT];
            lowPowerMode <= ratePower_q[LOW_POWER_BIT];
            outputRate <= ratePower_q[RATE_LSB +: 4];
            measureMode <= measureOn;
            asleepState <= asleepNow;
            sampleReadyAllowed <= measureOn & ~asleepNow;
            fifoWriteAllowed <= measureOn & ~asleepNow;
        end
    end
endmodule

// ---- dv/mepc_checker.sv ----
// port assertions for the motion event and power control block
`timescale 1ns/1ps
module mepc_checker (
    input wire logic ref_clk, reset, sampleValid, singleTapCandidate,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready, activityEvent, inactivityEvent,
    input wire logic freefallEvent, singleTapEvent, measureMode, asleepState,
    input wire logic sampleReadyAllowed, fifoWriteAllowed,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0] outputRate
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_write_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_read_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read answer");
    a_reset_state: assert property ($fell(reset)
        |-> !measureMode && outputRate == 4'hA) else $error("bad state after reset");
    a_sleep_gate: assert property (asleepState ##1 asleepState
        |-> !sampleReadyAllowed && !fifoWriteAllowed) else $error("sleep gating off");
    a_sleep_quiet: assert property ($past(asleepState) && asleepState
        |-> !inactivityEvent && !freefallEvent && !singleTapEvent) else $error("event asleep");
    a_event_cause: assert property (activityEvent || freefallEvent
        |-> $past(sampleValid)) else $error("event without sample");
    a_tap_cause: assert property (singleTapEvent |-> $past(singleTapCandidate))
        else $error("tap without candidate");
endmodule
bind mepc_top mepc_checker chk_u (.*);

// ---- dv/mepc_host.sv ----
// host model: register master issuing one access at a time
`timescale 1ns/1ps
module mepc_host (
    input wire logic ref_clk, s_axi_awready, s_axi_wready, s_axi_bvalid,
    input wire logic s_axi_arready, s_axi_rvalid,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    output logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0] s_axi_wstrb = 4'hF,
    output logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0,
    output logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0
);
    int tmo = 0;
    // released lines show the inverse so stale values never pass for fresh ones
    task automatic xfer(input bit we, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] q, output logic [1:0] r);
        bit p;
        bit w;
        p = 1;
        w = we;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_bready <= we;
        s_axi_arvalid <= !we;
        s_axi_rready <= !we;
        repeat (100) begin
            @(posedge ref_clk);
            if (!p && !w && (we ? s_axi_bvalid : s_axi_rvalid)) begin
                q = s_axi_rdata;
                r = we ? s_axi_bresp : s_axi_rresp;
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                return;
            end
            if (p && (we ? s_axi_awready : s_axi_arready)) begin
                p = 0;
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
                s_axi_awaddr <= ~s_axi_awaddr;
                s_axi_araddr <= ~s_axi_araddr;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 1'h0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end
        tmo++;
    endtask
endmodule

// ---- dv/mepc_top_tb.sv ----
// register and event sequences for the motion event and power control block
`timescale 1ns/1ps
module mepc_top_tb import mepc_pkg::*; ();
    logic ref_clk = 0, reset = 1, sampleValid = 0, singleTapCandidate = 0;
    logic doubleTapCandidate = 0, tapAboveThreshold = 0;
    logic [2:0] tapAxisHits = 3'h0, tapAxisEnable;
    mepc_axes_t sampleIn = '0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb, outputRate;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic activityEvent, inactivityEvent, freefallEvent, singleTapEvent, doubleTapEvent;
    logic improvedTapMode, lowPowerMode, measureMode, asleepState;
    logic sampleReadyAllowed, fifoWriteAllowed;
    int n_fail = 0, n_checks = 0;
    always #4 ref_clk = ~ref_clk;
    // short tick keeps the millisecond timers affordable in simulation
    mepc_top #(.TICK_CYCLES_P(10)) dut_u (.*);
    mepc_host host_u (.*);
    task chk(string s, logic [39:0] got, logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", s, exp, got);
        end
    endtask
    task wr(logic [7:0] i, logic [7:0] d, logic [1:0] e);
        host_u.xfer(1, {i[5:0], 2'h0}, d, q, r);
        chk("bresp", r, e);
    endtask
    task rd(logic [7:0] i, logic [7:0] e);
        host_u.xfer(0, {i[5:0], 2'h0}, 8'h00, q, r);
        chk("rdata", q, {24'h0, e});
    endtask
    task smp(logic signed [15:0] x, y, z);
        @(posedge ref_clk);
        sampleIn <= '{x, y, z};
        sampleValid <= 1'h1;
        @(posedge ref_clk);
        sampleValid <= 1'h0;
        #1;
    endtask
    task tap(logic s, logic d, logic a);
        @(posedge ref_clk);
        singleTapCandidate <= s;
        doubleTapCandidate <= d;
        tapAboveThreshold <= a;
        tapAxisHits <= 3'h3;
        @(posedge ref_clk);
        singleTapCandidate <= 1'h0;
        doubleTapCandidate <= 1'h0;
        tapAboveThreshold <= 1'h0;
        #1;
    endtask
    task conclude;
        n_fail += host_u.tmo;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'h0;
        @(posedge ref_clk);
        chk("standby", {measureMode, outputRate}, 5'h0A);
        for (int i = 0; i < 10; i++) begin
            rd(8'h24 + i[7:0], (i == 8) ? RATE_POWER_RESET : ZERO_RESET);
        end
        wr(IDX_TAP_AXIS, 8'hFF, RESP_OKAY);
        rd(IDX_TAP_AXIS, TAP_AXIS_MASK);
        chk("tapcfg", {improvedTapMode, tapAxisEnable}, 4'hF);
        wr(IDX_RATE_POWER, 8'hFF, RESP_OKAY);
        rd(IDX_RATE_POWER, RATE_POWER_MASK);
        chk("lowpower", {lowPowerMode, outputRate}, 5'h1F);
        wr(IDX_EVENT_SRC, 8'hFF, RESP_OKAY);
        rd(IDX_EVENT_SRC, 8'h00);
        wr(8'h00, 8'h55, RESP_SLVERR);
        host_u.xfer(0, 8'h00, 8'h00, q, r);
        chk("unmapped", {r, q}, {RESP_SLVERR, 32'h0});
        wr(IDX_TAP_AXIS, 8'h01, RESP_OKAY);
        wr(IDX_ACT_THR, 8'h01, RESP_OKAY);
        wr(IDX_FF_THR, 8'h05, RESP_OKAY);
        wr(IDX_FF_TIME, 8'h01, RESP_OKAY);
        wr(IDX_MOTION_AXIS, 8'h40, RESP_OKAY);
        wr(IDX_POWER_CONTROL, 8'h08, RESP_OKAY);
        smp(16'sd16, 16'sd900, 16'sd0);
        chk("act16", activityEvent, 1'h0);
        smp(16'sd17, 16'sd0, 16'sd0);
        chk("act17", activityEvent, 1'h1);
        rd(IDX_EVENT_SRC, 8'h40);
        smp(16'sd0, 16'sd0, 16'sd0);
        chk("ffearly", freefallEvent, 1'h0);
        repeat (60) @(posedge ref_clk);
        smp(16'sd0, 16'sd0, 16'sd79);
        chk("fall", freefallEvent, 1'h1);
        tap(1'h1, 1'h0, 1'h0);
        chk("tap", singleTapEvent, 1'h1);
        rd(IDX_EVENT_SRC, 8'h41);
        wr(IDX_TAP_AXIS, 8'h09, RESP_OKAY);
        tap(1'h0, 1'h1, 1'h0);
        chk("double", doubleTapEvent, 1'h1);
        tap(1'h1, 1'h0, 1'h0);
        tap(1'h0, 1'h1, 1'h1);
        chk("suppress", doubleTapEvent, 1'h0);
        wr(IDX_POWER_CONTROL, 8'h0C, RESP_OKAY);
        #1 chk("asleep", {asleepState, sampleReadyAllowed, fifoWriteAllowed}, 3'h4);
        rd(IDX_EVENT_SRC, 8'h49);
        wr(IDX_POWER_CONTROL, 8'h00, RESP_OKAY);
        #1 chk("awake", asleepState, 1'h0);
        wr(IDX_MOTION_AXIS, 8'h44, RESP_OKAY);
        wr(IDX_INACT_THR, 8'h02, RESP_OKAY);
        wr(IDX_POWER_CONTROL, 8'h38, RESP_OKAY);
        smp(16'sd0, 16'sd0, 16'sd0);
        chk("inact", inactivityEvent, 1'h1);
        rd(IDX_EVENT_SRC, 8'h49);
        conclude();
    end
endmodule
